// ===== bpt_pkg.sv
package bpt_pkg;
	// Channel count and bus widths
	localparam int BPT_NCH = 6;
	localparam int BPT_AW = 5;
	localparam int BPT_DW = 8;

	// Byte register offsets
	localparam logic [4:0] BPT_OFF_TSC = 5'h00;
	localparam logic [4:0] BPT_OFF_CNT_HI = 5'h01;
	localparam logic [4:0] BPT_OFF_CNT_LO = 5'h02;
	localparam logic [4:0] BPT_OFF_MOD_HI = 5'h03;
	localparam logic [4:0] BPT_OFF_MOD_LO = 5'h04;
	localparam logic [4:0] BPT_OFF_CH_BASE = 5'h05;
	localparam logic [4:0] BPT_CH_STRIDE = 5'h03;
	localparam logic [4:0] BPT_CH_CSR = 5'h00;
	localparam logic [4:0] BPT_CH_VHI = 5'h01;
	localparam logic [4:0] BPT_CH_VLO = 5'h02;

	// Timer control/status bit positions
	localparam int BPT_TSC_OVF = 7;
	localparam int BPT_TSC_OVIE = 6;
	localparam int BPT_TSC_HALT = 5;
	localparam int BPT_TSC_CLR = 4;

	// Channel control/status bit positions
	localparam int BPT_CSC_FLAG = 7;
	localparam int BPT_CSC_IE = 6;
	localparam int BPT_CSC_BUF = 5;
	localparam int BPT_CSC_UNB = 4;
	localparam int BPT_CSC_ACTB = 3;
	localparam int BPT_CSC_ACTA = 2;
	localparam int BPT_CSC_TOV = 1;
	localparam int BPT_CSC_MAX = 0;

	// Compare action codes
	localparam logic [1:0] BPT_ACT_NONE = 2'h0;
	localparam logic [1:0] BPT_ACT_TOGGLE = 2'h1;
	localparam logic [1:0] BPT_ACT_CLEAR = 2'h2;
	localparam logic [1:0] BPT_ACT_SET = 2'h3;

	// Prescale code for the external clock pin
	localparam logic [2:0] BPT_PS_EXT = 3'h7;

	// Values after reset
	localparam logic [7:0] BPT_TSC_RST = 8'h20;
	localparam logic [7:0] BPT_CSC_RST = 8'h00;
	localparam logic [15:0] BPT_MOD_RST = 16'hffff;
	localparam logic [15:0] BPT_VAL_RST = 16'h0000;
endpackage : bpt_pkg

// ===== bpt_chan.sv
`timescale 1ns/10ps
module bpt_chan
	import bpt_pkg::*;
(
	input wire logic clk_in, // Bus clock
	input wire logic rst_in, // Synchronous reset, high
	input wire logic drive_en_in, // Channel owns its pin
	input wire logic wrap_ev_in, // Counter wrap this cycle
	input wire logic cmp_ev_in, // Compare match this cycle
	input wire logic toggle_on_wrap_in, // Toggle at wrap
	input wire logic [1:0] action_in, // Compare action select
	input wire logic full_duty_in, // Full-duty request
	output logic pin_out, // Channel pin level
	output logic oe_out // Channel pin enable
);
	typedef struct packed {
		logic pin;
		logic oe;
	} bpt_chan_state_t;

	bpt_chan_state_t s;
	bpt_chan_state_t next_s;

	// Pin level: wrap toggle first, compare action last so it wins
	always_comb begin
		next_s = s;
		next_s.oe = drive_en_in;
		if (!drive_en_in) begin
			next_s.pin = 1'b0;
		end else if (full_duty_in && toggle_on_wrap_in) begin
			next_s.pin = ~action_in[0]; // Held at pulse level
		end else begin
			if (wrap_ev_in && toggle_on_wrap_in) begin
				next_s.pin = ~s.pin;
			end
			if (cmp_ev_in) begin
				unique case (action_in)
					BPT_ACT_TOGGLE: next_s.pin = ~next_s.pin;
					BPT_ACT_CLEAR: next_s.pin = 1'b0;
					BPT_ACT_SET: next_s.pin = 1'b1;
					BPT_ACT_NONE: next_s.pin = next_s.pin;
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign pin_out = s.pin;
	assign oe_out = s.oe;
endmodule : bpt_chan

// ===== bpt_timer.sv
`timescale 1ns/10ps
// How it works
// - Unbuffered value writes replace the compare value at once, no shadow.
// - Compare fires only on exact counter match; passed values are missed.
// - Channel flag sets at pulse end, overflow flag at period end.
// - Even channel buffer bit links next odd channel; even values start first.
// - Written inactive set takes over next period; last written governs each wrap.
// - Linked pair: even control reg rules, odd pin released as GPIO.
// - Mode select 0:1 is unbuffered, 1:0 is buffered.
// - Action 1:0 clears, 1:1 sets pin on compare.
// - Buffered select wins over unbuffered select.
// - Toggle-on-wrap clear gives 0% duty output.
// - Full-duty plus toggle-on-wrap gives 100% duty output.
// - Overflow flag sets at period limit; irq gated by its enable.
// - Channel flag sets on compare; irq gated by channel enable.
// - Timer runs in wait, registers locked, enabled irq wakes processor.
// - Pin toggles at period limit when toggle-on-wrap is set.
// - Clear bit zeroes counter and prescaler, self-clears, reads zero.
// - Prescale codes 0-6 divide by 1..64; code 7 uses external clock.
// - Flags clear by read-while-set then zero write; new event cancels.
module bpt_timer
	import bpt_pkg::*;
(
	input wire logic CLK_IN, // Bus clock, 100 MHz
	input wire logic SYS_RST_IN, // Synchronous reset, high
	input wire logic [BPT_AW-1:0] ADDR_IN, // Register byte address
	input wire logic [BPT_DW-1:0] WDATA_IN, // Write data
	input wire logic WR_IN, // Write strobe
	input wire logic RD_IN, // Read strobe
	input wire logic WAIT_IN, // Processor in wait mode
	input wire logic EXT_CLK_IN, // External counting clock pin
	output logic [BPT_DW-1:0] RDATA_OUT, // Read data, cycle after strobe
	output logic IRQ_OUT, // Any enabled timer request
	output logic WAKE_OUT, // Wake request during wait
	output logic [BPT_NCH-1:0] CH_OUT, // Channel pin levels
	output logic [BPT_NCH-1:0] CH_OE_OUT // Channel pin enables
);
	// Channel pairs that can be linked
	localparam int NP = BPT_NCH / 2;

	typedef struct packed {
		logic [15:0] cnt;
		logic [5:0] presc;
		logic ext_prev;
		logic ovf;
		logic ovf_armed;
		logic ovie;
		logic halt;
		logic [2:0] ps;
		logic [15:0] period;
		logic [7:0] period_hold;
		logic [BPT_NCH-1:0][7:0] csr;
		logic [BPT_NCH-1:0][15:0] val;
		logic [BPT_NCH-1:0] flag_armed;
		logic [7:0] val_hold;
		logic [NP-1:0] act;
		logic [NP-1:0] last_wr;
		logic [7:0] cnt_latch;
		logic cnt_latched;
		logic [7:0] rdata;
		logic irq;
		logic wake;
	} bpt_state_t;

	bpt_state_t s;
	bpt_state_t next_s;

	logic tick;
	logic wrap_ev;
	logic ext_rise;
	logic wr_ok;
	logic rd_ok;
	logic [BPT_NCH-1:0] cmp_ev;
	logic [BPT_NCH-1:0] drive_en;
	logic [BPT_NCH-1:0][15:0] eff_val;
	logic [NP-1:0] linked;

	// Mask of prescaler bits that must all be ones for a count
	function automatic logic [5:0] presc_mask(input logic [2:0] ps);
		presc_mask = 6'((7'h01 << ps) - 7'h01);
	endfunction : presc_mask

	// Address of one channel register
	function automatic logic ch_hit(input logic [4:0] addr, input int ch, input logic [4:0] kind);
		logic [4:0] base;
		base = BPT_OFF_CH_BASE + 5'(ch) * BPT_CH_STRIDE;
		ch_hit = (addr == base + kind);
	endfunction : ch_hit

	// Pair linking, compare source and pin ownership
	always_comb begin
		// Even channel's buffered select links the pair
		for (int p = 0; p < NP; p++) begin
			linked[p] = s.csr[2*p][BPT_CSC_BUF];
		end
		for (int i = 0; i < BPT_NCH; i++) begin
			if (i % 2 == 0) begin
				// Buffered select alone is enough; it outranks the other bit
				eff_val[i] = (linked[i/2] && s.act[i/2]) ? s.val[i+1] : s.val[i];
				drive_en[i] = (s.csr[i][BPT_CSC_BUF] || s.csr[i][BPT_CSC_UNB]) &&
					(s.csr[i][BPT_CSC_ACTB:BPT_CSC_ACTA] != BPT_ACT_NONE);
			end else begin
				eff_val[i] = s.val[i];
				// Odd channel of a linked pair lets go of its pin
				drive_en[i] = !linked[i/2] && s.csr[i][BPT_CSC_UNB] &&
					(s.csr[i][BPT_CSC_ACTB:BPT_CSC_ACTA] != BPT_ACT_NONE);
			end
		end
	end

	// Counting tick from prescaler or external pin
	always_comb begin
		// Pin sampled once a bus cycle, so it must stay below half the bus rate
		ext_rise = EXT_CLK_IN && !s.ext_prev;
		if (s.ps == BPT_PS_EXT) begin
			tick = !s.halt && ext_rise;
		end else begin
			tick = !s.halt && ((s.presc & presc_mask(s.ps)) == presc_mask(s.ps));
		end
		wrap_ev = tick && (s.cnt == s.period);
		for (int i = 0; i < BPT_NCH; i++) begin
			// Exact match only, a value already passed waits a period
			cmp_ev[i] = tick && (s.cnt == eff_val[i]) && !(i % 2 == 1 && linked[i/2]);
		end
		// Registers are shut off from the processor in wait mode
		wr_ok = WR_IN && !WAIT_IN;
		rd_ok = RD_IN && !WAIT_IN;
	end

	// Next state: counting, bus access, then event flags so sets win
	always_comb begin
		next_s = s;
		next_s.ext_prev = EXT_CLK_IN;
		if (!s.halt) begin
			next_s.presc = s.presc + 6'h01;
		end
		if (tick) begin
			next_s.cnt = wrap_ev ? 16'h0000 : s.cnt + 16'h0001;
		end
		// Active set of each pair moves at the wrap, and resets to the even set when a link starts
		for (int p = 0; p < NP; p++) begin
			if (wrap_ev) begin
				next_s.act[p] = linked[p] ? s.last_wr[p] : 1'b0;
			end
		end

		// Reads and their side effects
		if (rd_ok) begin
			next_s.rdata = 8'h00;
			if (ADDR_IN == BPT_OFF_TSC) begin
				next_s.rdata = {s.ovf, s.ovie, s.halt, 1'b0, 1'b0, s.ps};
				next_s.ovf_armed = s.ovf;
			end else if (ADDR_IN == BPT_OFF_CNT_HI) begin
				next_s.rdata = s.cnt[15:8];
				// Latch kept until the low byte is read, so repeated high reads do not move it
				if (!s.cnt_latched) begin
					next_s.cnt_latch = s.cnt[7:0];
				end
				next_s.cnt_latched = 1'b1;
			end else if (ADDR_IN == BPT_OFF_CNT_LO) begin
				next_s.rdata = s.cnt_latched ? s.cnt_latch : s.cnt[7:0];
				next_s.cnt_latched = 1'b0;
			end else if (ADDR_IN == BPT_OFF_MOD_HI) begin
				next_s.rdata = s.period[15:8];
			end else if (ADDR_IN == BPT_OFF_MOD_LO) begin
				next_s.rdata = s.period[7:0];
			end
			// Channel registers; a status read arms the flag clear
			for (int i = 0; i < BPT_NCH; i++) begin
				if (ch_hit(ADDR_IN, i, BPT_CH_CSR)) begin
					next_s.rdata = s.csr[i];
					next_s.flag_armed[i] = s.csr[i][BPT_CSC_FLAG];
				end
				if (ch_hit(ADDR_IN, i, BPT_CH_VHI)) begin
					next_s.rdata = s.val[i][15:8];
				end
				if (ch_hit(ADDR_IN, i, BPT_CH_VLO)) begin
					next_s.rdata = s.val[i][7:0];
				end
			end
		end

		// Writes
		if (wr_ok) begin
			if (ADDR_IN == BPT_OFF_TSC) begin
				next_s.ovie = WDATA_IN[BPT_TSC_OVIE];
				next_s.halt = WDATA_IN[BPT_TSC_HALT];
				next_s.ps = WDATA_IN[2:0];
				// Zero write clears only after a read that saw the flag
				if (!WDATA_IN[BPT_TSC_OVF] && s.ovf_armed) begin
					next_s.ovf = 1'b0;
				end
				next_s.ovf_armed = 1'b0;
				// Clear bit is a pulse, never stored
				if (WDATA_IN[BPT_TSC_CLR]) begin
					next_s.cnt = 16'h0000;
					next_s.presc = 6'h00;
				end
			end else if (ADDR_IN == BPT_OFF_MOD_HI) begin
				// Period high byte waits for its low byte
				next_s.period_hold = WDATA_IN;
			end else if (ADDR_IN == BPT_OFF_MOD_LO) begin
				next_s.period = {s.period_hold, WDATA_IN};
			end
			// Channel registers; the flag bit obeys the two-step clear
			for (int i = 0; i < BPT_NCH; i++) begin
				if (ch_hit(ADDR_IN, i, BPT_CH_CSR)) begin
					next_s.csr[i][6:0] = WDATA_IN[6:0];
					if (!WDATA_IN[BPT_CSC_FLAG] && s.flag_armed[i]) begin
						next_s.csr[i][BPT_CSC_FLAG] = 1'b0;
					end
					next_s.flag_armed[i] = 1'b0;
					// Fresh link starts from the even set
					if (i % 2 == 0 && WDATA_IN[BPT_CSC_BUF] && !s.csr[i][BPT_CSC_BUF]) begin
						next_s.act[i/2] = 1'b0;
						next_s.last_wr[i/2] = 1'b0;
					end
				end
				if (ch_hit(ADDR_IN, i, BPT_CH_VHI)) begin
					// High byte parked until the low byte commits
					next_s.val_hold = WDATA_IN;
				end
				// Low byte commits the whole word; an inactive linked set waits for the wrap
				if (ch_hit(ADDR_IN, i, BPT_CH_VLO)) begin
					next_s.val[i] = {s.val_hold, WDATA_IN};
					if (linked[i/2]) begin
						next_s.last_wr[i/2] = (i % 2 == 1);
					end
				end
			end
		end

		// Event flags; a set in the clearing cycle is kept
		if (wrap_ev) begin
			next_s.ovf = 1'b1;
			next_s.ovf_armed = 1'b0;
		end
		for (int i = 0; i < BPT_NCH; i++) begin
			if (cmp_ev[i]) begin
				next_s.csr[i][BPT_CSC_FLAG] = 1'b1;
				next_s.flag_armed[i] = 1'b0;
			end
		end

		// Request from the flags as they will stand
		next_s.irq = next_s.ovf && next_s.ovie;
		for (int i = 0; i < BPT_NCH; i++) begin
			// Odd member of a linked pair raises nothing; even index keeps the select in range
			if (next_s.csr[i][BPT_CSC_FLAG] && next_s.csr[i][BPT_CSC_IE] &&
				!(i % 2 == 1 && next_s.csr[2 * (i / 2)][BPT_CSC_BUF])) begin
				next_s.irq = 1'b1;
			end
		end
		next_s.wake = next_s.irq && WAIT_IN;
	end

	// State register
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			// Halted with an all-ones period until software sets it up
			s <= '0;
			s.halt <= BPT_TSC_RST[BPT_TSC_HALT];
			s.period <= BPT_MOD_RST;
			for (int i = 0; i < BPT_NCH; i++) begin
				s.csr[i] <= BPT_CSC_RST;
				s.val[i] <= BPT_VAL_RST;
			end
		end else begin
			s <= next_s;
		end
	end

	// One pin stage per channel; odd stage is idle while linked
	for (genvar g = 0; g < BPT_NCH; g++) begin : g_chan
		bpt_chan u_chan (
			.clk_in(CLK_IN),
			.rst_in(SYS_RST_IN),
			.drive_en_in(drive_en[g]),
			.wrap_ev_in(wrap_ev),
			.cmp_ev_in(cmp_ev[g]),
			.toggle_on_wrap_in(s.csr[g][BPT_CSC_TOV]),
			.action_in(s.csr[g][BPT_CSC_ACTB:BPT_CSC_ACTA]),
			.full_duty_in(s.csr[g][BPT_CSC_MAX]),
			.pin_out(CH_OUT[g]),
			.oe_out(CH_OE_OUT[g])
		);
	end

	// Outputs straight from the state register
	assign RDATA_OUT = s.rdata;
	assign IRQ_OUT = s.irq;
	assign WAKE_OUT = s.wake;
endmodule : bpt_timer

// ===== bpt_timer_assertions.sv
`timescale 1ns/10ps
module bpt_timer_assertions
	import bpt_pkg::*;
(
	input wire logic CLK_IN, // Clock
	input wire logic SYS_RST_IN, // Reset
	input wire logic [BPT_AW-1:0] ADDR_IN, // Address
	input wire logic [BPT_DW-1:0] WDATA_IN, // Write data
	input wire logic WR_IN, // Write
	input wire logic RD_IN, // Read
	input wire logic WAIT_IN, // Wait mode
	input wire logic [BPT_DW-1:0] RDATA_OUT, // Read data
	input wire logic IRQ_OUT, // Request
	input wire logic WAKE_OUT, // Wake
	input wire logic [BPT_NCH-1:0] CH_OE_OUT // Pin enables
);
	typedef struct packed {
		logic [6:0] en;
		logic [2:0] link;
	} bpt_shadow_t;
	bpt_shadow_t st;
	bpt_shadow_t next_st;
	wire acc_wr = WR_IN && !WAIT_IN;
	wire acc_rd = RD_IN && !WAIT_IN;
	// Shadow enables and links; wait-mode writes never land
	always_comb begin
		next_st = st;
		if (acc_wr && ADDR_IN == BPT_OFF_TSC)
			next_st.en[6] = WDATA_IN[BPT_TSC_OVIE];
		for (int i = 0; i < BPT_NCH; i++) begin
			if (acc_wr && ADDR_IN == BPT_OFF_CH_BASE + 5'(3 * i)) begin
				next_st.en[i] = WDATA_IN[BPT_CSC_IE];
				if (i % 2 == 0)
					next_st.link[i / 2] = WDATA_IN[BPT_CSC_BUF];
			end
		end
		if (SYS_RST_IN)
			next_st = '0;
	end
	always_ff @(posedge CLK_IN) begin
		st <= next_st;
	end
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	sequence s_clear_halt;
		acc_wr && ADDR_IN == BPT_OFF_TSC && WDATA_IN[BPT_TSC_CLR] && WDATA_IN[BPT_TSC_HALT];
	endsequence
	sequence s_read_count;
		acc_rd && ADDR_IN == BPT_OFF_CNT_HI;
	endsequence
	AST_CLEAR_COUNT: assert property (s_clear_halt ##1 !acc_wr ##1 s_read_count |=> RDATA_OUT == 8'h00)
		else $error("counter not zero after clear with halt");
	AST_CLEAR_READS_ZERO: assert property (acc_rd && ADDR_IN == BPT_OFF_TSC |=> !RDATA_OUT[BPT_TSC_CLR])
		else $error("clear bit read back as one");
	AST_WAIT_RD_IGNORED: assert property (RD_IN && WAIT_IN |=> $stable(RDATA_OUT))
		else $error("read accepted during wait");
	AST_WAKE_NEEDS_WAIT: assert property (WAKE_OUT |-> $past(WAIT_IN))
		else $error("wake outside wait");
	AST_WAKE_NEEDS_IRQ: assert property (WAKE_OUT |-> IRQ_OUT || $past(IRQ_OUT))
		else $error("wake without request");
	AST_WAKE_FOLLOWS_IRQ: assert property ($past(WAIT_IN) && $past(WAIT_IN, 2) && IRQ_OUT && $past(IRQ_OUT) |-> WAKE_OUT)
		else $error("request in wait did not wake");
	AST_IRQ_GATED: assert property (IRQ_OUT |-> (|st.en) || (|$past(st.en)))
		else $error("request with all enables clear");
	AST_ODD_RELEASED: assert property ((st.link & $past(st.link) & {CH_OE_OUT[5], CH_OE_OUT[3], CH_OE_OUT[1]}) == 3'h0)
		else $error("spare pin driven while pair linked");
endmodule : bpt_timer_assertions

bind bpt_timer bpt_timer_assertions u_chk (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .ADDR_IN(ADDR_IN),
	.WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .WAIT_IN(WAIT_IN), .RDATA_OUT(RDATA_OUT),
	.IRQ_OUT(IRQ_OUT), .WAKE_OUT(WAKE_OUT), .CH_OE_OUT(CH_OE_OUT));

// ===== test_buffered_pwm_timer.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module test_buffered_pwm_timer;
	import bpt_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] addr = 5'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic wait_mode = 1'b0;
	logic [2:0] ext_div = 3'h0;
	logic [7:0] rdata;
	logic irq;
	logic wake;
	logic [5:0] ch;
	logic [5:0] ch_oe;
	logic [7:0] v;
	logic [4:0] b;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	int w;
	int d;
	bpt_timer uut (.CLK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
		.WAIT_IN(wait_mode), .EXT_CLK_IN(ext_div[2]), .RDATA_OUT(rdata), .IRQ_OUT(irq), .WAKE_OUT(wake),
		.CH_OUT(ch), .CH_OE_OUT(ch_oe));
	// Bus clock; external count clock rises every eighth bus cycle
	always #5 clk = ~clk;
	always @(posedge clk) begin
		ext_div <= ext_div + 3'h1;
	end
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	// Cut a hung run short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] x);
		@(posedge clk);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] x);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		x = rdata;
	endtask : rd_reg
	// High byte first: the low byte commits the word
	task automatic wr16(input logic [4:0] a, input logic [15:0] x);
		wr_reg(a, x[15:8]);
		wr_reg(a + 5'h01, x[7:0]);
	endtask : wr16
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// Settle two periods first, since a mid-period change may miss a compare
	task automatic pwm_chk(input int i, input int len, input int e);
		logic [15:0] h;
		h = 16'h0000;
		// Writes not timed to the handlers may misbehave for two periods
		repeat (2 * len) @(posedge clk);
		repeat (2 * len) begin
			@(posedge clk);
			#1;
			h = h + 16'(ch[i]); // An unknown pin level poisons the count
		end
		`CHK("pin high count", e, h)
		`CHK("pin enable", 1'b1, ch_oe[i])
	endtask : pwm_chk
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd_reg(BPT_OFF_TSC, v);
		`CHK("tsc reset", BPT_TSC_RST, v)
		wr_reg(BPT_OFF_TSC, 8'h30);
		rd_reg(BPT_OFF_CNT_HI, v);
		`CHK("count cleared", 8'h00, v)
		rd_reg(BPT_OFF_TSC, v);
		`CHK("clear reads zero", 8'h20, v)
		// Period 4 ticks; clear/set actions with widths 1 and 2, never toggle on compare
		wr16(BPT_OFF_MOD_HI, 16'h0003);
		wr_reg(BPT_OFF_TSC, 8'h00);
		for (int k = 0; k < 4; k++) begin
			w = k % 2 + 1;
			wr16(5'h06, 16'(w));
			wr_reg(5'h05, (k < 2) ? 8'h5a : 8'h5e);
			pwm_chk(0, 4, (k < 2) ? 2 * (w + 1) : 2 * (3 - w));
		end
		// Flags, their requests and the two-step clear
		wr_reg(BPT_OFF_TSC, 8'h20);
		rd_reg(5'h05, v);
		`CHK("channel flag", 8'hde, v)
		`CHK("channel request", 1'b1, irq)
		rd_reg(BPT_OFF_TSC, v);
		`CHK("unarmed write keeps flag", 8'ha0, v)
		wr_reg(BPT_OFF_TSC, 8'h20);
		rd_reg(BPT_OFF_TSC, v);
		`CHK("overflow cleared", 8'h20, v)
		wr_reg(5'h05, 8'h1a);
		tick(2);
		`CHK("request dropped", 1'b0, irq)
		rd_reg(5'h05, v);
		`CHK("channel flag cleared", 8'h1a, v)
		wr_reg(BPT_OFF_TSC, 8'h00);
		tick(8);
		`CHK("overflow masked", 1'b0, irq)
		wr_reg(BPT_OFF_TSC, 8'h40);
		tick(2);
		`CHK("overflow request", 1'b1, irq)
		// Wait mode: counting goes on, bus locked, request wakes
		@(posedge clk);
		wait_mode <= 1'b1;
		wr_reg(BPT_OFF_TSC, 8'h20);
		rd_reg(BPT_OFF_TSC, v);
		tick(2);
		`CHK("wake", 1'b1, wake)
		pwm_chk(0, 4, 6);
		@(posedge clk);
		wait_mode <= 1'b0;
		rd_reg(BPT_OFF_TSC, v);
		`CHK("tsc after wait", 8'hc0, v)
		`CHK("no wake outside wait", 1'b0, wake)
		wr_reg(5'h05, 8'h18);
		pwm_chk(0, 4, 0);
		wr_reg(5'h05, 8'h1b);
		pwm_chk(0, 4, 8);
		// Every prescale code, the last one on the external clock
		wr_reg(5'h05, 8'h1a);
		wr16(5'h06, 16'h0001);
		for (int k = 0; k < 8; k++) begin
			d = (k == 7) ? 8 : (1 << k);
			wr_reg(BPT_OFF_TSC, {5'h00, 3'(k)});
			pwm_chk(0, 4 * d, 4 * d);
		end
		// Each pair: even set first, then the last written set per wrap
		wr_reg(BPT_OFF_TSC, 8'h00);
		for (int p = 0; p < 3; p++) begin
			b = 5'(5 + 6 * p);
			wr_reg(b + 5'h03, 8'h1a);
			wr16(b + 5'h01, 16'h0001);
			wr_reg(b, 8'h3a);
			pwm_chk(2 * p, 4, 4);
			`CHK("spare pin released", 1'b0, ch_oe[2 * p + 1])
			wr16(b + 5'h04, 16'h0002);
			pwm_chk(2 * p, 4, 6);
			wr16(b + 5'h01, 16'h0000);
			pwm_chk(2 * p, 4, 2);
			// Unlinked again, the spare channel runs its own width of 2
			wr_reg(b, 8'h00);
			pwm_chk(2 * p + 1, 4, 6);
			wr_reg(b + 5'h03, 8'h00);
		end
		report_and_stop();
	end
endmodule : test_buffered_pwm_timer
